// ---- dof_host.sv ----
// Host model issuing command reads and writes.
`timescale 1ns/1ns
`default_nettype none
module dof_host (
    input wire logic sys_clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_nack
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Data is inverted once released so a stale word is never reused.
    task automatic wr(input logic [7:0] c, input logic [15:0] d,
                      output logic n);
        @(posedge sys_clk);
        cmd_wr <= 1'b1;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
        cmd_wdata <= ~d;
        #1 n = cmd_nack;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(posedge sys_clk);
        cmd_rd <= 1'b1;
        cmd_code <= c;
        @(posedge sys_clk);
        cmd_rd <= 1'b0;
        #1 d = cmd_rdata;
    endtask
endmodule
`default_nettype wire

// ---- dof_overheat.sv ----
// Die overtemperature threshold, action register and fault response.
`timescale 1ns/1ns
`default_nettype none

module dof_overheat #(
    parameter int RESTART_CYCLES = dof_pkg::RESTART_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Command access from the management bus engine.
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_nack,
    // Nonvolatile restore of the stored settings.
    input wire logic nvm_load,
    input wire logic [5:0] nvm_mantissa,
    input wire logic nvm_retry_bit,
    // Telemetry, enable, and status clears.
    input wire logic [7:0] die_temp_c,
    input wire logic conv_enable,
    input wire logic flag_clear,
    input wire logic cml_clear,
    // Status and power stage control.
    output logic overheat_fault_flag,
    output logic cml_summary,
    output logic cml_invalid_data,
    output logic host_alert_line_n,
    output logic output_enable
);
    logic [5:0] mant_r;
    logic retry_r;
    logic [15:0] cmd_rdata_r;
    logic cmd_nack_r;
    logic flag_r;
    logic cml_r;
    logic ivd_r;
    logic en_d_r;
    logic [31:0] wait_cnt_r;
    dof_pkg::dof_state_t state_r;
    logic [7:0] applied_c;
    logic over_temp;
    logic wr_thr, wr_act, bad_thr, bad_act;
    logic [2:0] retry_field;

    // Snap a mantissa to the hardware's temperature setting.
    // Results are whole degrees Celsius, from 115 up to 150 in steps of 5.
    function automatic logic [7:0] snap_temp(input logic [5:0] m);
        if (m < 6'h1e) begin
            snap_temp = 8'h73;
        end else if (m == 6'h1e) begin
            snap_temp = 8'h78;
        end else if (m == 6'h1f) begin
            snap_temp = 8'h7d;
        end else if (m < 6'h22) begin
            snap_temp = 8'h82;
        end else if (m == 6'h22) begin
            snap_temp = 8'h87;
        end else if (m == 6'h23) begin
            snap_temp = 8'h8c;
        end else if (m == 6'h24) begin
            snap_temp = 8'h91;
        end else begin
            snap_temp = 8'h96;
        end
    endfunction

    // Canonical code stored per setting, used on restore.
    function automatic logic [5:0] fixed_code(input logic [5:0] m);
        if (m < dof_pkg::THR_MANT_LOW) begin
            fixed_code = 6'h1d;
        end else if (m == 6'h21) begin
            fixed_code = 6'h20;
        end else if (m > dof_pkg::THR_MANT_HIGH) begin
            fixed_code = 6'h25;
        end else begin
            fixed_code = m;
        end
    endfunction

    assign retry_field = {3{retry_r}};
    assign wr_thr = cmd_wr && cmd_code == dof_pkg::THRESHOLD_CODE;
    assign wr_act = cmd_wr && cmd_code == dof_pkg::ACTION_CODE;
    // Any change to the upper bits counts, so they must match what reads back.
    assign bad_thr = wr_thr && cmd_wdata[15:6] != {dof_pkg::THR_EXPONENT,
        5'h00};
    assign bad_act = wr_act && (cmd_wdata[5:3] != dof_pkg::RETRY_LATCH &&
        cmd_wdata[5:3] != dof_pkg::RETRY_AUTO);
    assign applied_c = snap_temp(mant_r);
    assign over_temp = die_temp_c >= applied_c;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mant_r <= dof_pkg::THR_MANT_DEFAULT;
        end else if (nvm_load) begin
            mant_r <= fixed_code(nvm_mantissa);
        end else if (wr_thr && !bad_thr) begin
            mant_r <= cmd_wdata[5:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            retry_r <= dof_pkg::RETRY_BIT_DEFAULT;
        end else if (nvm_load) begin
            retry_r <= nvm_retry_bit;
        end else if (wr_act && !bad_act) begin
            retry_r <= cmd_wdata[5];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_rdata_r <= 16'h0000;
        end else if (cmd_rd) begin
            if (cmd_code == dof_pkg::THRESHOLD_CODE) begin
                cmd_rdata_r <= {dof_pkg::THR_EXPONENT, 5'h00,
                    mant_r};
            end else if (cmd_code == dof_pkg::ACTION_CODE) begin
                cmd_rdata_r <= {8'h00, 1'b1, 1'b0, retry_field,
                    retry_field};
            end else if (cmd_code == dof_pkg::COMM_STATUS_CODE) begin
                cmd_rdata_r <= {8'h00, 1'b0, ivd_r, 6'h00};
            end else begin
                cmd_rdata_r <= 16'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_nack_r <= 1'b0;
        end else begin
            cmd_nack_r <= bad_thr || bad_act;
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cml_r <= 1'b0;
            ivd_r <= 1'b0;
        end else if (bad_thr || bad_act) begin
            cml_r <= 1'b1;
            ivd_r <= 1'b1;
        end else if (cml_clear) begin
            cml_r <= 1'b0;
            ivd_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (over_temp && state_r == dof_pkg::DOF_RUN) begin
            flag_r <= 1'b1;
        end else if (flag_clear) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Resets high so an enable held high through reset is no toggle.
            en_d_r <= 1'b1;
        end else begin
            en_d_r <= conv_enable;
        end
    end

    // The wait counter only matters while restarting, so it reloads on entry.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= dof_pkg::DOF_RUN;
            wait_cnt_r <= 32'h0000_0000;
        end else begin
            unique case (state_r)
                dof_pkg::DOF_RUN: begin
                    if (over_temp) begin
                        if (retry_r) begin
                            state_r <= dof_pkg::DOF_WAIT;
                        end else begin
                            state_r <= dof_pkg::DOF_LATCHED;
                        end
                        wait_cnt_r <= 32'h0000_0000;
                    end
                end
                dof_pkg::DOF_LATCHED: begin
                    if (!flag_r && conv_enable && !en_d_r) begin
                        state_r <= dof_pkg::DOF_RUN;
                    end
                end
                dof_pkg::DOF_WAIT: begin
                    if (!conv_enable) begin
                        state_r <= dof_pkg::DOF_RUN;
                    end else if (wait_cnt_r >= 32'(RESTART_CYCLES - 1)) begin
                        state_r <= dof_pkg::DOF_RUN;
                    end else begin
                        wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
                    end
                end
                default: begin
                    state_r <= dof_pkg::DOF_RUN;
                end
            endcase
        end
    end

    assign cmd_rdata = cmd_rdata_r;
    assign cmd_nack = cmd_nack_r;
    assign overheat_fault_flag = flag_r;
    assign cml_summary = cml_r;
    assign cml_invalid_data = ivd_r;
    assign host_alert_line_n = !(flag_r || cml_r);
    assign output_enable = conv_enable &&
        state_r == dof_pkg::DOF_RUN;
endmodule

`default_nettype wire

// ---- dof_overheat_monitor.sv ----
// Port checker for the overheat threshold and action block.
`timescale 1ns/1ns
`default_nettype none
module dof_mon (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic nvm_load,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_nack,
    input wire logic overheat_fault_flag,
    input wire logic cml_summary,
    input wire logic cml_invalid_data,
    input wire logic host_alert_line_n,
    input wire logic output_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence thr_wr_s;
        cmd_wr && !nvm_load && cmd_code == 8'h4f;
    endsequence
    alert_level_a: assert property (
        host_alert_line_n != (overheat_fault_flag | cml_summary))
        else $error("alert level wrong");
    thr_bad_a: assert property (
        thr_wr_s ##0 (cmd_wdata[15:6] != 10'h040) |=> cmd_nack)
        else $error("bad threshold write accepted");
    thr_good_a: assert property (
        thr_wr_s ##0 (cmd_wdata[15:6] == 10'h040) |=> !cmd_nack)
        else $error("good threshold write refused");
    retry_bad_a: assert property (cmd_wr && !nvm_load &&
        cmd_code == 8'h50 && cmd_wdata[4:3] != {2{cmd_wdata[5]}} |=> cmd_nack)
        else $error("bad retry write accepted");
    nack_flags_a: assert property (
        cmd_nack |-> cml_summary && cml_invalid_data)
        else $error("refusal without status");
    thr_fixed_a: assert property (
        cmd_rd && cmd_code == 8'h4f |=> cmd_rdata[15:6] == 10'h040)
        else $error("threshold fixed bits wrong");
    act_fixed_a: assert property (cmd_rd && cmd_code == 8'h50
        |=> cmd_rdata[15:6] == 10'h002 && cmd_rdata[5:3] == cmd_rdata[2:0])
        else $error("action fixed bits wrong");
    fault_off_a: assert property (
        $rose(overheat_fault_flag) |-> !output_enable)
        else $error("output runs in fault");
endmodule
`default_nettype wire

// ---- dof_pkg.sv ----
// Package with register codes, field layouts and timing for the overheat block.
package dof_pkg;
    localparam logic [7:0] THRESHOLD_CODE = 8'h4f;
    localparam logic [7:0] ACTION_CODE = 8'h50;
    localparam logic [7:0] COMM_STATUS_CODE = 8'h7e;
    localparam logic [4:0] THR_EXPONENT = 5'h02;
    localparam int THR_EXP_MSB = 15;
    localparam int THR_EXP_LSB = 11;
    localparam int THR_RO_MSB = 15;
    localparam int THR_RO_LSB = 6;
    localparam int THR_MANT_W = 6;
    localparam logic [5:0] THR_MANT_DEFAULT = 6'h22;
    localparam logic [5:0] THR_MANT_LOW = 6'h1e;
    localparam logic [5:0] THR_MANT_HIGH = 6'h25;
    localparam int ACT_FIXED_BIT = 7;
    localparam int ACT_UNUSED_BIT = 6;
    localparam int ACT_RETRY_MSB = 5;
    localparam int ACT_RETRY_LSB = 3;
    localparam logic [2:0] RETRY_LATCH = 3'h0;
    localparam logic [2:0] RETRY_AUTO = 3'h7;
    localparam logic RETRY_BIT_DEFAULT = 1'b0;
    localparam int CML_IVD_BIT = 6;
    localparam int RESTART_DELAY_MS = 52;
    localparam int CLK_HZ = 20000000;
    localparam int RESTART_CYCLES = RESTART_DELAY_MS * (CLK_HZ / 1000);
    typedef enum logic [1:0] {
        DOF_RUN,
        DOF_LATCHED,
        DOF_WAIT
    } dof_state_t;
endpackage

// ---- test_die_overheat_fault_config.sv ----
// Testbench for the overheat threshold and action block.
`timescale 1ns/1ns
`default_nettype none
module test_die_overheat_fault_config;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_wr, cmd_rd, cmd_nack, nvm_load, nvm_retry_bit, conv_enable;
    logic flag_clear, cml_clear, overheat_fault_flag, cml_summary, n;
    logic cml_invalid_data, host_alert_line_n, output_enable;
    logic [7:0] cmd_code, die_temp_c;
    logic [15:0] cmd_wdata, cmd_rdata, d;
    logic [5:0] nvm_mantissa;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    always #25 sys_clk = ~sys_clk;
    // A short restart count keeps the auto-restart case quick.
    dof_overheat #(.RESTART_CYCLES(20)) dut_u (.sys_clk, .rst_n, .cmd_wr,
        .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_nack, .nvm_load,
        .nvm_mantissa, .nvm_retry_bit, .die_temp_c, .conv_enable,
        .flag_clear, .cml_clear, .overheat_fault_flag, .cml_summary,
        .cml_invalid_data, .host_alert_line_n, .output_enable);
    dof_host host_u (.sys_clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
        .cmd_rdata, .cmd_nack);
    task automatic chk(input string s, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] c, input logic [15:0] e, string s);
        host_u.rd(c, d);
        chk(s, d, e);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic t_limit;
        host_u.wr(8'h4f, 16'h1023, n);
        chk("thr nack", n, 1'b0);
        rc(8'h4f, 16'h1023, "thr back");
        @(posedge sys_clk);
        die_temp_c <= 8'd139;
        wt(3);
        chk("below", overheat_fault_flag, 1'b0);
        @(posedge sys_clk);
        die_temp_c <= 8'd140;
        wt(3);
        chk("at", overheat_fault_flag, 1'b1);
        chk("alert", host_alert_line_n, 1'b0);
        @(posedge sys_clk);
        die_temp_c <= 8'd25;
        flag_clear <= 1'b1;
        @(posedge sys_clk);
        flag_clear <= 1'b0;
        wt(30);
        chk("latched", output_enable, 1'b0);
        @(posedge sys_clk);
        conv_enable <= 1'b0;
        @(posedge sys_clk);
        conv_enable <= 1'b1;
        wt(3);
        chk("rerun", output_enable, 1'b1);
    endtask
    task automatic t_bad;
        host_u.wr(8'h4f, 16'h0023, n);
        chk("thr refuse", n, 1'b1);
        chk("cml set", cml_summary, 1'b1);
        chk("ivd set", cml_invalid_data, 1'b1);
        rc(8'h4f, 16'h1023, "thr kept");
        rc(8'h7e, 16'h0040, "ivd");
        rc(8'h51, 16'h0000, "unmapped");
        @(posedge sys_clk);
        cml_clear <= 1'b1;
        @(posedge sys_clk);
        cml_clear <= 1'b0;
        wt(0);
        chk("cml clear", cml_summary, 1'b0);
        chk("ivd clear", cml_invalid_data, 1'b0);
        chk("alert off", host_alert_line_n, 1'b1);
        host_u.wr(8'h50, 16'h0028, n);
        chk("retry refuse", n, 1'b1);
        rc(8'h50, 16'h0080, "act kept");
    endtask
    initial begin
        nvm_load = 1'b0;
        nvm_mantissa = 6'h21;
        nvm_retry_bit = 1'b1;
        die_temp_c = 8'd25;
        conv_enable = 1'b1;
        flag_clear = 1'b0;
        cml_clear = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rc(8'h4f, 16'h1022, "thr reset");
        rc(8'h50, 16'h0080, "act reset");
        t_limit;
        t_bad;
        @(posedge sys_clk);
        nvm_load <= 1'b1;
        @(posedge sys_clk);
        nvm_load <= 1'b0;
        rc(8'h4f, 16'h1020, "thr restore");
        rc(8'h50, 16'h00bf, "act restore");
        host_u.wr(8'h50, 16'h0038, n);
        chk("auto nack", n, 1'b0);
        @(posedge sys_clk);
        die_temp_c <= 8'd200;
        wt(3);
        chk("auto off", output_enable, 1'b0);
        @(posedge sys_clk);
        die_temp_c <= 8'd25;
        wt(10);
        chk("auto wait", output_enable, 1'b0);
        wt(12);
        chk("auto on", output_enable, 1'b1);
        stop_test();
    end
endmodule
bind dof_overheat dof_mon mon_u (.sys_clk, .rst_n, .cmd_wr, .cmd_rd,
    .nvm_load, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_nack,
    .overheat_fault_flag, .cml_summary, .cml_invalid_data,
    .host_alert_line_n, .output_enable);
`default_nettype wire
